// ==== rtl/sorb_regs.svh ====
// register offsets, field positions, reset values and timing counts of the scratch/offset/id bank
`ifndef SORB_REGS_SVH
`define SORB_REGS_SVH
`define SORB_ADDR_UNLOCK 8'h04
`define SORB_ADDR_WORD_A 8'h05
`define SORB_ADDR_WORD_B 8'h06
`define SORB_ADDR_OFFSET 8'h07
`define SORB_ADDR_WORD_C 8'h08
`define SORB_ADDR_IDENT 8'h0F
`define SORB_UNLOCK_BIT 15
`define SORB_BUSY_BIT 14
`define SORB_REV_MSB 15
`define SORB_REV_LSB 12
`define SORB_PART_MSB 11
`define SORB_PART_LSB 0
`define SORB_OFFSET_RESET 16'h0000
`define SORB_UNLOCK_RESET 16'h0000
// arbitrary revision and part codes, not those of any real part
`define SORB_REV_VALUE 4'h5
`define SORB_PART_VALUE 12'hA5C
`define SORB_TEMP_MAX 16'h7FFF
`define SORB_TEMP_MIN 16'h8000
`define SORB_PROG_TIME_US 7
`define SORB_CLK_MHZ 125
`define SORB_PROG_CYCLES ((`SORB_PROG_TIME_US * `SORB_CLK_MHZ))
`endif

// ==== rtl/sorb_pkg.sv ====
// types of the scratch/offset/id bank
package sorb_pkg;
   typedef enum logic [1:0] {sorb_load_a, sorb_load_b, sorb_load_c, sorb_idle} sorb_state_type;
   typedef logic [1:0] sorb_cell_type;
endpackage

// ==== rtl/sorb_nvm.sv ====
// small nonvolatile cell array model with registered read data
`timescale 1ns/100ps
module sorb_nvm
   import sorb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire sorb_cell_type wr_cell,
   input wire logic [15:0] wr_data,
   input wire sorb_cell_type rd_cell,
   output logic [15:0] rd_data
);
   // cell 3 is the fourth cell, kept but not mapped to a register
   logic [15:0] mem [0:3];

   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_cell] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      rd_data <= mem[rd_cell];
   end
endmodule

// ==== rtl/sorb_bank.sv ====
// user store words, temperature offset with saturation, and identification word
`timescale 1ns/100ps
`include "sorb_regs.svh"
module sorb_bank
   import sorb_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic temp_valid,
   input wire logic [15:0] temp_lin,
   output logic [15:0] reg_rdata_q,
   output logic [15:0] temp_out_q,
   output logic temp_out_valid_q,
   output logic nvm_busy_q,
   output logic nvm_unlock_control_q
);
   // ******************************
   // helpers
   // ******************************
   function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] s;
      s = {a[15], a} + {b[15], b};
      if (s[16] != s[15]) begin
         sat_add = s[16] ? `SORB_TEMP_MIN : `SORB_TEMP_MAX;
      end else begin
         sat_add = s[15:0];
      end
   endfunction

   function automatic logic is_word(input logic [7:0] a);
      is_word = (a == `SORB_ADDR_WORD_A) || (a == `SORB_ADDR_WORD_B) || (a == `SORB_ADDR_WORD_C);
   endfunction

   function automatic sorb_cell_type cell_of(input logic [7:0] a);
      case (a)
         `SORB_ADDR_WORD_A: cell_of = 2'h0;
         `SORB_ADDR_WORD_B: cell_of = 2'h1;
         default: cell_of = 2'h2;
      endcase
   endfunction

   // ******************************
   // state
   // ******************************
   localparam int prog_cycles = `SORB_PROG_CYCLES;
   localparam logic [15:0] unlock_reset = `SORB_UNLOCK_RESET;
   sorb_state_type state_q;
   logic [15:0] word_a_q, word_b_q, word_c_q, offset_q;
   logic load_pend_q;
   logic [15:0] prog_cnt_q;
   logic nvm_wr;
   sorb_cell_type nvm_rd_cell;
   logic [15:0] nvm_rd_data;
   logic host_word_wr;
   logic [15:0] ident;

   assign ident = {`SORB_REV_VALUE, `SORB_PART_VALUE}; // arbitrary id value
   // word writes during load or programming are dropped to keep register and cell coherent
   assign host_word_wr = reg_wr && is_word(reg_addr) && !nvm_busy_q;
   assign nvm_wr = host_word_wr && nvm_unlock_control_q;

   always_comb begin
      case (state_q)
         sorb_load_a: nvm_rd_cell = 2'h0;
         sorb_load_b: nvm_rd_cell = 2'h1;
         default: nvm_rd_cell = 2'h2;
      endcase
   end

   sorb_nvm u_nvm (
      .ref_clk(ref_clk),
      .wr_en(nvm_wr),
      .wr_cell(cell_of(reg_addr)),
      .wr_data(reg_wdata),
      .rd_cell(nvm_rd_cell),
      .rd_data(nvm_rd_data)
   );

   // ******************************
   // power-up load sequence
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= sorb_load_a;
         load_pend_q <= 1'b0;
      end else begin
         case (state_q)
            sorb_load_a: begin
               if (load_pend_q) begin
                  state_q <= sorb_load_b;
               end
               load_pend_q <= ~load_pend_q;
            end
            sorb_load_b: begin
               if (load_pend_q) begin
                  state_q <= sorb_load_c;
               end
               load_pend_q <= ~load_pend_q;
            end
            sorb_load_c: begin
               if (load_pend_q) begin
                  state_q <= sorb_idle;
               end
               load_pend_q <= ~load_pend_q;
            end
            default: begin
               state_q <= sorb_idle;
               load_pend_q <= 1'b0;
            end
         endcase
      end
   end

   // ******************************
   // user store words
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         word_a_q <= 16'h0000;
         word_b_q <= 16'h0000;
         word_c_q <= 16'h0000;
      end else if (load_pend_q && state_q != sorb_idle) begin
         case (state_q)
            sorb_load_a: word_a_q <= nvm_rd_data;
            sorb_load_b: word_b_q <= nvm_rd_data;
            default: word_c_q <= nvm_rd_data;
         endcase
      end else if (host_word_wr) begin
         case (reg_addr)
            `SORB_ADDR_WORD_A: word_a_q <= reg_wdata;
            `SORB_ADDR_WORD_B: word_b_q <= reg_wdata;
            default: word_c_q <= reg_wdata;
         endcase
      end
   end

   // ******************************
   // programming busy timer
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         prog_cnt_q <= 16'h0000;
      end else if (nvm_wr) begin
         prog_cnt_q <= prog_cycles[15:0];
      end else if (prog_cnt_q != 16'h0000) begin
         prog_cnt_q <= prog_cnt_q - 16'h0001;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nvm_busy_q <= 1'b1;
      end else begin
         nvm_busy_q <= nvm_wr || (prog_cnt_q > 16'h0001) ||
            (state_q != sorb_idle && !(state_q == sorb_load_c && load_pend_q));
      end
   end

   // ******************************
   // unlock and offset registers
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         nvm_unlock_control_q <= unlock_reset[`SORB_UNLOCK_BIT];
         offset_q <= `SORB_OFFSET_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `SORB_ADDR_UNLOCK) begin
            nvm_unlock_control_q <= reg_wdata[`SORB_UNLOCK_BIT];
         end
         if (reg_addr == `SORB_ADDR_OFFSET) begin
            offset_q <= reg_wdata;
         end
      end
   end

   // ******************************
   // offset adder
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         temp_out_q <= 16'h0000;
         temp_out_valid_q <= 1'b0;
      end else begin
         temp_out_valid_q <= temp_valid;
         if (temp_valid) begin
            temp_out_q <= sat_add(temp_lin, offset_q);
         end
      end
   end

   // ******************************
   // read path
   // ******************************
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata_q <= 16'h0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `SORB_ADDR_UNLOCK: reg_rdata_q <= {nvm_unlock_control_q, nvm_busy_q, 14'h0000};
            `SORB_ADDR_WORD_A: reg_rdata_q <= word_a_q;
            `SORB_ADDR_WORD_B: reg_rdata_q <= word_b_q;
            `SORB_ADDR_OFFSET: reg_rdata_q <= offset_q;
            `SORB_ADDR_WORD_C: reg_rdata_q <= word_c_q;
            `SORB_ADDR_IDENT: reg_rdata_q <= ident;
            default: reg_rdata_q <= 16'h0000;
         endcase
      end
   end

   // ******************************
   // checks
   // ******************************
   sequence s_temp_in;
      temp_valid;
   endsequence
   sequence s_temp_out;
      temp_out_valid_q;
   endsequence

   sat_high_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_temp_in and (!temp_lin[15] && !offset_q[15] && (temp_lin + offset_q) > 16'h7FFF)
      |=> s_temp_out and temp_out_q == `SORB_TEMP_MAX) else $error("positive overflow not clamped");
   sat_low_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      temp_valid && temp_lin[15] && offset_q[15] && !(temp_lin[14:0] + offset_q[14:0] >= 16'h8000)
      |=> temp_out_q == `SORB_TEMP_MIN) else $error("negative overflow not clamped");
   offset_add_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      temp_valid && (temp_lin[15] != offset_q[15]) |=> temp_out_q == $past(temp_lin) + $past(offset_q))
      else $error("offset sum wrong");
   locked_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      host_word_wr && !nvm_unlock_control_q |=> !nvm_busy_q) else $error("locked write started programming");
   unlocked_write_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      host_word_wr && nvm_unlock_control_q |=> nvm_busy_q[*2]) else $error("unlocked write did not program");
   word_b_store_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      host_word_wr && reg_addr == `SORB_ADDR_WORD_B |=> word_b_q == $past(reg_wdata))
      else $error("word b not stored");
   ident_read_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_rd && reg_addr == `SORB_ADDR_IDENT |=> reg_rdata_q == {`SORB_REV_VALUE, `SORB_PART_VALUE})
      else $error("id word wrong");
   load_done_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      $rose(resetn) |-> ##[0:8] state_q == sorb_idle) else $error("power-up load too slow");
   unlock_bit_a: assert property (@(posedge ref_clk) disable iff (!resetn)
      reg_wr && reg_addr == `SORB_ADDR_UNLOCK |=> nvm_unlock_control_q == $past(reg_wdata[15]))
      else $error("unlock bit not taken");
endmodule

// ==== sim/sorb_host.sv ====
// host model driving the register strobes of the bank
`timescale 1ns/100ps
module sorb_host (
   input wire logic ref_clk,
   input wire logic [15:0] reg_rdata_q,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata
);
   // ************
   // bus tasks
   // ************
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 16'h0000;
   end
   // released lines show the inverse, so a stale value never passes for a held one
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      #1 reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge ref_clk);
      #1 reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      #1 reg_rd = 1'b1;
      reg_addr = a;
      @(posedge ref_clk);
      #1 reg_rd = 1'b0;
      reg_addr = ~a;
      @(posedge ref_clk);
      #1 d = reg_rdata_q;
   endtask
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the scratch/offset/id bank
`timescale 1ns/100ps
`include "sorb_regs.svh"
module tb;
   logic ref_clk, resetn, reg_wr, reg_rd, temp_valid, temp_out_valid_q, nvm_busy_q, nvm_unlock_control_q;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, temp_lin, reg_rdata_q, temp_out_q;
   logic [7:0] words [3] = '{`SORB_ADDR_WORD_A, `SORB_ADDR_WORD_B, `SORB_ADDR_WORD_C};
   logic [15:0] e_t [4] = '{16'h7F00, 16'h8000, 16'h0100, 16'h7FFF};
   logic [15:0] e_o [4] = '{16'h0200, 16'hFFFF, 16'hFF00, 16'h0000};
   int miscompares = 0;
   int samples_checked = 0;
   logic [15:0] exp_q [$];
   int cycles = 0;
   sorb_bank sorb_bank_inst (.ref_clk(ref_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .temp_valid(temp_valid), .temp_lin(temp_lin),
      .reg_rdata_q(reg_rdata_q), .temp_out_q(temp_out_q), .temp_out_valid_q(temp_out_valid_q),
      .nvm_busy_q(nvm_busy_q), .nvm_unlock_control_q(nvm_unlock_control_q));
   sorb_host sorb_host_inst (.ref_clk(ref_clk), .reg_rdata_q(reg_rdata_q), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   // ************
   // clock, timeout, helpers
   // ************
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // ceiling well above one programming wait plus traffic
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      while (nvm_busy_q !== 1'b0 && n < 1000) begin
         @(posedge ref_clk);
         #1 n++;
      end
      check({15'h0000, nvm_busy_q}, 16'h0000);
   endtask
   task automatic do_reset();
      resetn = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1 resetn = 1'b1;
      wait_idle();
   endtask
   // signed sum clamped to the 16-bit range
   function automatic logic [15:0] sat(input logic [15:0] t, input logic [15:0] o);
      int s;
      s = int'($signed(t)) + int'($signed(o));
      if (s > 32767) s = 32767;
      else if (s < -32768) s = -32768;
      return s[15:0];
   endfunction
   task automatic send(input logic [15:0] t, input logic [15:0] o);
      exp_q.push_back(sat(t, o));
      @(posedge ref_clk);
      #1 temp_valid = 1'b1;
      temp_lin = t;
      @(posedge ref_clk);
      #1 temp_valid = 1'b0;
      temp_lin = ~t;
      check({15'h0000, temp_out_valid_q}, 16'h0001);
      check(temp_out_q, exp_q.pop_front());
   endtask
   // ************
   // main sequence
   // ************
   initial begin
      logic [15:0] d, v, w, o, t;
      void'($urandom(4));
      resetn = 1'b0;
      temp_valid = 1'b0;
      temp_lin = 16'h0000;
      do_reset();
      sorb_host_inst.rd(`SORB_ADDR_OFFSET, d);
      check(d, `SORB_OFFSET_RESET);
      sorb_host_inst.wr(`SORB_ADDR_IDENT, 16'h0000);
      sorb_host_inst.rd(`SORB_ADDR_IDENT, d);
      check(d, {`SORB_REV_VALUE, `SORB_PART_VALUE});
      sorb_host_inst.rd(8'h0A, d);
      check(d, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         v = 16'($urandom);
         sorb_host_inst.wr(words[i], v);
         check({15'h0000, nvm_busy_q}, 16'h0000);
         sorb_host_inst.rd(words[i], d);
         check(d, v);
         w = v;
      end
      sorb_host_inst.wr(`SORB_ADDR_UNLOCK, 16'h8000);
      check({15'h0000, nvm_unlock_control_q}, 16'h0001);
      v = 16'($urandom);
      // first word left alone on purpose
      sorb_host_inst.wr(`SORB_ADDR_WORD_B, v);
      check({15'h0000, nvm_busy_q}, 16'h0001);
      sorb_host_inst.rd(`SORB_ADDR_UNLOCK, d);
      check(d, 16'hC000);
      // word writes while programming are dropped
      sorb_host_inst.wr(`SORB_ADDR_WORD_C, ~w);
      sorb_host_inst.rd(`SORB_ADDR_WORD_C, d);
      check(d, w);
      wait_idle();
      sorb_host_inst.wr(`SORB_ADDR_UNLOCK, 16'h0000);
      check({15'h0000, nvm_unlock_control_q}, 16'h0000);
      w = ~v;
      sorb_host_inst.wr(`SORB_ADDR_WORD_B, w);
      sorb_host_inst.rd(`SORB_ADDR_WORD_B, d);
      check(d, w);
      do_reset();
      sorb_host_inst.rd(`SORB_ADDR_WORD_B, d);
      check(d, v);
      for (int i = 0; i < 24; i++) begin
         o = (i < 4) ? e_o[i] : 16'($urandom);
         t = (i < 4) ? e_t[i] : 16'($urandom);
         sorb_host_inst.wr(`SORB_ADDR_OFFSET, o);
         send(t, o);
      end
      report_and_stop();
   end
endmodule
